// [hw/rstwd_pkg.sv]
// Package: constants and types of the reset and watchdog controller
package rstwd_pkg;
  localparam int unsigned CLK_HZ            = 200_000_000;
  localparam int unsigned OSC_PER_MC        = 12;          // Oscillator periods per machine cycle
  localparam int unsigned POR_DELAY_OSC     = 21504;       // Power-on delay, oscillator periods
  localparam int unsigned EXT_MIN_MC        = 2;           // Least external reset hold, machine cycles
  localparam int unsigned WDT_TIMEOUT_MC    = 122880;      // Watchdog timeout, machine cycles
  localparam int unsigned CNT_W             = 17;
  localparam logic [7:0]  TA_KEY1           = 8'hAA;
  localparam logic [7:0]  TA_KEY2           = 8'h55;
  localparam logic [3:0]  PART_ADDR_LOW_VLI = 4'hF;
  localparam logic        RANGE_32K         = 1'b0;        // Range code selecting 32K bytes
  localparam logic [15:0] RESET_VECTOR      = 16'h0000;
  localparam logic [1:0]  RANGE_RST         = 2'h0;

  typedef enum logic [1:0] {
    RSTWD_RUN  = 2'b00,
    RSTWD_POR  = 2'b01,
    RSTWD_EXT  = 2'b10,
    RSTWD_WAIT = 2'b11
  } rstwd_state_t;

  typedef enum logic [1:0] {
    RSTWD_TA_IDLE = 2'b00,
    RSTWD_TA_KEY1 = 2'b01,
    RSTWD_TA_OPEN = 2'b10
  } rstwd_ta_t;
endpackage : rstwd_pkg

// [hw/rstwd_ctrl.sv]
// Reset sequencer, watchdog and timed-access gate
`timescale 1ns/1ps
module rstwd_ctrl
  import rstwd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        osc_tick,
  input  wire logic        backup_cell_voltage,
  input  wire logic        ext_rst_pin,
  input  wire logic        stop_mode,
  input  wire logic        has_encryption,
  input  wire logic        has_periph_select,
  input  wire logic        ta_wr,
  input  wire logic [7:0]  ta_wdata,
  input  wire logic        power_control_reg_wr,
  input  wire logic        power_control_reg_por_wdata,
  input  wire logic        power_control_reg_ewt_wdata,
  input  wire logic        prio_wr,
  input  wire logic        prio_rwt_wdata,
  input  wire logic        mem_wr,
  input  wire logic [3:0]  mem_part_wdata,
  input  wire logic [1:0]  mem_range_wdata,
  input  wire logic        mem_ce2_wdata,
  input  wire logic        mem_pes_wdata,
  input  wire logic        flag_clr,
  output logic             int_rst,
  output logic [15:0]      fetch_addr,
  output logic             int_enable_all,
  output logic             por_flag,
  output logic             watchdog_enable_bit,
  output logic             watchdog_reset_flag,
  output logic [3:0]       partition_address_field,
  output logic             range_sel,
  output logic             encrypt_key_en,
  output logic             sw_encrypt_en,
  output logic             security_lock,
  output logic             peripheral_select_bit,
  output logic             second_chip_enable_bit,
  output logic             ta_open
);
  import rstwd_pkg::*;

  // ----------------------------------------------------------------
  // Timing derived from oscillator periods
  // ----------------------------------------------------------------
  localparam int unsigned EXT_MIN_OSC = EXT_MIN_MC * OSC_PER_MC;
  localparam logic [CNT_W-1:0] POR_LAST  = CNT_W'(POR_DELAY_OSC - 1);
  localparam logic [CNT_W-1:0] EXT_LAST  = CNT_W'(EXT_MIN_OSC - 1);
  localparam logic [CNT_W-1:0] WDT_LAST  = CNT_W'(WDT_TIMEOUT_MC - 1);
  localparam logic [3:0]       MC_LAST   = 4'(OSC_PER_MC - 1);

  // ----------------------------------------------------------------
  // Pin synchroniser, three stages
  // ----------------------------------------------------------------
  logic [2:0] pin_sync_r;
  logic       pin_lvl_r;
  always_ff @(posedge clk_sys) begin
    pin_sync_r <= {pin_sync_r[1:0], ext_rst_pin};
    if (sys_rst) begin
      pin_lvl_r <= 1'b0;
    end else if (pin_sync_r[1] == pin_sync_r[2]) begin
      pin_lvl_r <= pin_sync_r[2];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  rstwd_state_t     state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             from_stop_r;
  logic [3:0]       mc_div_r;
  logic [CNT_W-1:0] wdt_r;
  logic             first_r;

  wire mc_tick     = osc_tick && (mc_div_r == MC_LAST);
  wire wdt_expire  = watchdog_enable_bit && mc_tick && (wdt_r == WDT_LAST);
  wire ext_valid   = (state_r == RSTWD_EXT) && osc_tick && (cnt_r == EXT_LAST);
  wire por_done    = (state_r == RSTWD_POR) && osc_tick && (cnt_r == POR_LAST);
  wire ext_release = (state_r == RSTWD_WAIT) && !pin_lvl_r;
  wire low_vli     = por_done && first_r && !backup_cell_voltage;
  wire rwt_write   = prio_wr && prio_rwt_wdata && ta_open;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      RSTWD_RUN: begin
        if (pin_lvl_r) begin
          state_nxt = RSTWD_EXT;
          cnt_nxt   = '0;
        end
      end
      RSTWD_POR: begin  // Pin ignored here
        if (osc_tick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
        if (por_done) begin
          state_nxt = RSTWD_RUN;
          cnt_nxt   = '0;
        end
      end
      RSTWD_EXT: begin
        if (!pin_lvl_r) begin
          state_nxt = RSTWD_RUN;
        end else if (ext_valid) begin
          state_nxt = RSTWD_WAIT;
        end else if (osc_tick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      RSTWD_WAIT: begin
        if (ext_release) begin
          // Stop mode halted the oscillator: restart delay on release
          state_nxt = from_stop_r ? RSTWD_POR : RSTWD_RUN;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = RSTWD_POR;
        cnt_nxt   = '0;
      end
    endcase
    if (wdt_expire) begin
      state_nxt = RSTWD_WAIT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r     <= RSTWD_POR;
      cnt_r       <= '0;
      first_r     <= 1'b1;
      from_stop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (por_done) begin
        first_r <= 1'b0;
      end
      if (state_r == RSTWD_RUN) begin
        from_stop_r <= stop_mode;
      end
    end
  end

  // A pin pulse still being qualified is not yet a reset: a glitch must not
  // clear the gate, the watchdog count or the peripheral select
  wire in_reset = (state_r == RSTWD_POR) || (state_r == RSTWD_WAIT) || wdt_expire;
  assign int_rst        = in_reset;
  assign fetch_addr     = RESET_VECTOR;
  assign int_enable_all = 1'b0;                     // Interrupts left to software

  // ----------------------------------------------------------------
  // Watchdog counter on machine cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst || in_reset) begin
      mc_div_r <= '0;
      wdt_r    <= '0;
    end else begin
      if (osc_tick) begin
        mc_div_r <= (mc_div_r == MC_LAST) ? 4'h0 : mc_div_r + 4'h1;
      end
      if (!watchdog_enable_bit || rwt_write) begin
        wdt_r <= '0;
      end else if (mc_tick) begin
        wdt_r <= wdt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timed-access gate
  // ----------------------------------------------------------------
  rstwd_ta_t ta_r;
  wire prot_wr = power_control_reg_wr || prio_wr || mem_wr;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || in_reset) begin
      ta_r <= RSTWD_TA_IDLE;
    end else begin
      case (ta_r)
        RSTWD_TA_IDLE: ta_r <= (ta_wr && ta_wdata == TA_KEY1) ? RSTWD_TA_KEY1 : RSTWD_TA_IDLE;
        RSTWD_TA_KEY1: begin
          if (ta_wr && ta_wdata == TA_KEY2) begin
            ta_r <= RSTWD_TA_OPEN;
          end else if (ta_wr || prot_wr) begin
            ta_r <= RSTWD_TA_IDLE;
          end
        end
        RSTWD_TA_OPEN: begin
          if (prot_wr || ta_wr) begin
            ta_r <= RSTWD_TA_IDLE;                  // One write only
          end
        end
        default: ta_r <= RSTWD_TA_IDLE;
      endcase
    end
  end
  assign ta_open = (ta_r == RSTWD_TA_OPEN);

  // ----------------------------------------------------------------
  // Control and status bits; sys_rst is power loss, so a full load
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      por_flag                <= 1'b0;
      watchdog_enable_bit     <= 1'b0;
      watchdog_reset_flag     <= 1'b0;
      partition_address_field <= PART_ADDR_LOW_VLI;
      range_sel               <= RANGE_32K;
      encrypt_key_en          <= 1'b0;
      sw_encrypt_en           <= 1'b0;
      security_lock           <= 1'b0;
      peripheral_select_bit   <= 1'b0;
      second_chip_enable_bit  <= 1'b0;
    end else if (low_vli) begin
      por_flag                <= 1'b0;
      watchdog_enable_bit     <= 1'b0;
      partition_address_field <= PART_ADDR_LOW_VLI;
      range_sel               <= RANGE_32K;
      if (has_encryption) begin
        encrypt_key_en <= 1'b0;
        sw_encrypt_en  <= 1'b0;
      end
      security_lock <= 1'b0;
    end else if (wdt_expire) begin
      watchdog_reset_flag <= 1'b1;                  // Set wins over clear
      if (has_periph_select) begin
        peripheral_select_bit <= 1'b0;
      end
    end else if (in_reset) begin
      // Map, enables and flags kept; only peripheral select drops
      if (has_periph_select) begin
        peripheral_select_bit <= 1'b0;
      end
    end else begin
      if (flag_clr) begin
        watchdog_reset_flag <= 1'b0;
      end
      if (power_control_reg_wr) begin
        por_flag <= power_control_reg_por_wdata;
        if (ta_open) begin
          watchdog_enable_bit <= power_control_reg_ewt_wdata;
        end
      end
      if (mem_wr && ta_open) begin
        partition_address_field <= mem_part_wdata;
        range_sel               <= mem_range_wdata[0];
        second_chip_enable_bit  <= mem_ce2_wdata;   // Kept across reset
        peripheral_select_bit   <= mem_pes_wdata;
      end
    end
  end
endmodule : rstwd_ctrl

// [verification/rstwd_props.sv]
// Port checker for the reset and watchdog controller
`timescale 1ns/1ps
module rstwd_props
  import rstwd_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        ta_wr,
  input wire logic [7:0]  ta_wdata,
  input wire logic        power_control_reg_wr,
  input wire logic        prio_wr,
  input wire logic        mem_wr,
  input wire logic        int_rst,
  input wire logic [15:0] fetch_addr,
  input wire logic        int_enable_all,
  input wire logic        watchdog_enable_bit,
  input wire logic        watchdog_reset_flag,
  input wire logic [3:0]  partition_address_field,
  input wire logic        ta_open
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire prot_wr = power_control_reg_wr || prio_wr || mem_wr;
  sequence s_keys;
    ta_wr && ta_wdata == TA_KEY1 && !ta_open && !int_rst ##1
    ta_wr && ta_wdata == TA_KEY2 && !int_rst && !prot_wr;
  endsequence
  a_vector_fixed: assert property (fetch_addr == RESET_VECTOR)
    else $error("fetch address off the reset vector");
  a_irq_off: assert property (!int_enable_all)
    else $error("interrupt sources enabled");
  a_gate_opens: assert property (s_keys |=> ta_open)
    else $error("gate stayed shut after both keys");
  a_gate_keyed: assert property (
    $rose(ta_open) |-> $past(ta_wr) && $past(ta_wdata) == TA_KEY2)
    else $error("gate opened without second key");
  a_gate_once: assert property (ta_open && prot_wr && !int_rst |=> !ta_open)
    else $error("gate left open after protected write");
  a_ewt_gated: assert property (
    $changed(watchdog_enable_bit) |-> $past(ta_open) || $past(int_rst) || $past(sys_rst))
    else $error("watchdog enable changed without gate");
  a_wdt_cause: assert property (
    $rose(watchdog_reset_flag) |-> $past(int_rst) && $past(watchdog_enable_bit))
    else $error("watchdog flag set without enabled expiry");
  // Partition is nonvolatile, so no reset but sys_rst and the low-voltage power-on load may move it
  a_map_kept: assert property (
    $rose(int_rst) && !$past(sys_rst) |=> $stable(partition_address_field)[*3])
    else $error("partition changed by reset");
endmodule : rstwd_props

// [verification/rstwd_ext_src.sv]
// Model of the external reset source on the reset pin
`timescale 1ns/1ps
module rstwd_ext_src (
  input wire logic clk_sys,
  output logic     ext_rst_pin
);
  initial ext_rst_pin = 1'b0;
  // Held for whole cycles; under 24 oscillator periods it is only a glitch
  task hold(int cycles);
    @(posedge clk_sys) #1 ext_rst_pin = 1'b1;
    repeat (cycles) @(posedge clk_sys);
    #1 ext_rst_pin = 1'b0;
  endtask : hold
endmodule : rstwd_ext_src

// [verification/test_rstwd_ctrl.sv]
// Self-checking bench for the reset and watchdog controller
`timescale 1ns/1ps
module test_rstwd_ctrl;
  import rstwd_pkg::*;
  logic        clk_sys = 0, sys_rst = 1, osc_tick = 1, backup_cell_voltage = 0, stop_mode = 0;
  logic        has_encryption = 1, has_periph_select = 1, flag_clr = 0, ta_wr = 0;
  logic        power_control_reg_wr = 0, prio_wr = 0, mem_wr = 0, power_control_reg_por_wdata = 0, power_control_reg_ewt_wdata = 0;
  logic        prio_rwt_wdata = 0, mem_ce2_wdata = 0, mem_pes_wdata = 0, ext_rst_pin;
  logic [7:0]  ta_wdata = 8'h00;
  logic [3:0]  mem_part_wdata = 4'h0, partition_address_field;
  logic [1:0]  mem_range_wdata = 2'h0;
  logic [15:0] fetch_addr;
  logic        int_rst, int_enable_all, por_flag, watchdog_enable_bit, watchdog_reset_flag;
  logic        range_sel, encrypt_key_en, sw_encrypt_en, security_lock, ta_open;
  logic        peripheral_select_bit, second_chip_enable_bit;
  int          num_errors = 0, checked = 0, n;

  rstwd_ctrl i_rstwd_ctrl (.*);
  rstwd_ext_src i_rstwd_ext_src (.clk_sys(clk_sys), .ext_rst_pin(ext_rst_pin));
  initial forever #2.5 clk_sys = ~clk_sys;

  task step();
    @(posedge clk_sys) #1;
  endtask : step
  task chk(string what, logic [19:0] seen, logic [19:0] exp);
    checked++;
    if (seen !== exp) num_errors++;
    if (seen !== exp) $display("ERROR %s expected %h seen %h", what, exp, seen);
  endtask : chk
  task gate();
    {ta_wr, ta_wdata} = {1'b1, TA_KEY1};
    step();
    {ta_wr, ta_wdata} = {1'b1, TA_KEY2};
    step();
    ta_wr = 0;
  endtask : gate
  // One strobe per call: power_control_reg, prio, mem
  task wr(logic [2:0] k);
    {power_control_reg_wr, prio_wr, mem_wr} = k;
    step();
    {power_control_reg_wr, prio_wr, mem_wr} = 3'b000;
    step();
  endtask : wr
  task wrel(int lim);
    for (n = 0; int_rst !== 1'b0 && n < lim; n++) step();
  endtask : wrel
  // ----
  // Scenarios
  // ----
  task t_power_on();
    fork
      begin
        repeat (POR_DELAY_OSC - 100) @(posedge clk_sys);
        i_rstwd_ext_src.hold(40);
      end
    join_none
    wrel(30000);
    chk("por_len", n >= POR_DELAY_OSC && n <= POR_DELAY_OSC + 8, 1'b1);
    chk("low_init", {por_flag, watchdog_enable_bit, partition_address_field, range_sel,
      encrypt_key_en, sw_encrypt_en, security_lock}, {2'b00, PART_ADDR_LOW_VLI, RANGE_32K,
      3'b000});
    chk("vector", {fetch_addr, int_enable_all}, {RESET_VECTOR, 1'b0});
    $display("done power_on");
  endtask : t_power_on
  task t_access();
    backup_cell_voltage = 1;
    {mem_range_wdata, mem_ce2_wdata, mem_pes_wdata, mem_part_wdata} = {2'h1, 2'b11, 4'h5};
    wr(3'b001);
    chk("map_locked", partition_address_field, 4'hF);
    gate();
    wr(3'b001);
    chk("map_set", {partition_address_field, range_sel, second_chip_enable_bit,
      peripheral_select_bit}, {4'h5, 3'b111});
    mem_part_wdata = 4'h3;
    wr(3'b001);
    chk("one_shot", partition_address_field, 4'h5);
    {power_control_reg_por_wdata, power_control_reg_ewt_wdata, prio_rwt_wdata} = 3'b111;
    wr(3'b100);
    chk("ewt_locked", watchdog_enable_bit, 1'b0);
    gate();
    wr(3'b100);
    chk("ewt_set", {watchdog_enable_bit, por_flag}, 2'b11);
    gate();
    wr(3'b010);
    chk("gate_shut", ta_open, 1'b0);
    $display("done access");
  endtask : t_access
  task t_ext();
    i_rstwd_ext_src.hold(10);
    repeat (8) step();
    chk("short_pin", peripheral_select_bit, 1'b1);
    i_rstwd_ext_src.hold(30);
    wrel(100);
    chk("ext_kept", {partition_address_field, range_sel, second_chip_enable_bit,
      watchdog_enable_bit, por_flag, peripheral_select_bit}, {4'h5, 5'b11110});
    $display("done ext");
  endtask : t_ext
  task t_stop();
    stop_mode = 1;
    i_rstwd_ext_src.hold(30);
    repeat (10) step();
    chk("stop_hold", int_rst, 1'b1);
    wrel(30000);
    stop_mode = 0;
    chk("stop_len", n + 10 >= POR_DELAY_OSC && n + 10 <= POR_DELAY_OSC + 10, 1'b1);
    $display("done stop");
  endtask : t_stop
  task results();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  initial begin
    repeat (2) step();
    sys_rst = 0;
    t_power_on();
    t_access();
    t_ext();
    t_stop();
    results();
  end
  // Both long delays together stay well under this span
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    results();
  end
endmodule : test_rstwd_ctrl

bind rstwd_ctrl rstwd_props i_rstwd_props (.*);
